/* File: rtl/hdlc_cmd_mode.v */
// Command interpreter, mode registers and serial engines of the controller
`timescale 1ns/10ps
//
// Behaviour
// - Preframe option sends two sync characters, 00 under NRZI else 55.
// - Buffered option keeps first two received bytes; cleared passes them.
// - Early option raises transmit end interrupt when last data byte taken.
// - Transmit command after early interrupt chains frames, no flag interrupt.
// - Without early option, transmit end interrupt follows the closing flag.
// - With abort select cleared, eight ones in a row mean abort.
// - NRZI bit codes transmit and decodes receive; cleared uses plain bits.
// - Clock loopback feeds transmit clock to the receiver.
// - Data loopback feeds transmitted data to the receiver input.
// - Data transfer mode set requests bytes by interrupt, else by DMA.
// - One-bit delay mode repeats received stream on transmit output.
// - Mode set/reset codes A4/64, 97/57, 91/51, A0/60, one mask each.
// - Mode commands give no result byte and no interrupt.
// - Receive commands C0, C1, C5 parameters and receive result sequence.
// - Transmit C8, C9 and aborts CC, CD parameters and transmit result.
// - Non-buffered mode omits address and control from receive results.
// - Reset sets every mode register bit to one.
// - Set commands OR the mask, reset commands AND the mask.
// - Busy sets on command write, clears after the last parameter taken.
// - Parameter-full sets on host write, clears when device takes it.
module hdlc_cmd_mode
(
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Host register port
  input wire [1:0] hostAddr,
  input wire hostWr,
  input wire hostRd,
  input wire [7:0] hostWrData,
  output reg [7:0] hostRdData,
  // Transmit data stream from memory
  input wire [7:0] txByte,
  input wire txByteValid,
  output wire txByteReady,
  // Receive data stream to memory
  output wire [7:0] rxByteData,
  output wire rxByteValid,
  input wire rxByteReady,
  // Requests to processor and DMA controller
  output wire txDmaReq,
  output wire rxDmaReq,
  output wire txIrq,
  output wire rxIrq,
  // Serial link pins
  input wire txClkPin,
  input wire rxClkPin,
  input wire rxDataPin,
  output reg txDataPin
);
`include "hdlc_consts.vh"

  // ----------------------------------------------------------------
  // Pin synchronisers and clock edge detection
  // ----------------------------------------------------------------
  reg [2:0] pinS1_reg;
  reg [2:0] pinS2_reg;
  reg [1:0] clkS3_reg;
  reg [7:0] serMode_reg;
  always @(posedge mclk)
  begin
    pinS1_reg <= {rxDataPin, rxClkPin, txClkPin};
    pinS2_reg <= pinS1_reg;
    clkS3_reg <= pinS2_reg[1:0];
  end
  // Shift on the falling transmit edge so the receiver samples mid bit
  wire txFall = clkS3_reg[0] & ~pinS2_reg[0];
  wire txRise = ~clkS3_reg[0] & pinS2_reg[0];
  wire rxRiseExt = ~clkS3_reg[1] & pinS2_reg[1];
  wire rxTick = serMode_reg[`HDLC_SER_CLKLOOP] ? txRise : rxRiseExt;

  // ----------------------------------------------------------------
  // Command phase and mode registers
  // ----------------------------------------------------------------
  reg [7:0] opMode_reg;
  reg [7:0] xfrMode_reg;
  reg [7:0] dlyMode_reg;
  reg [7:0] cmd_reg;
  reg [7:0] param_reg;
  reg [7:0] paramMem_reg [0:3];
  reg [2:0] paramIdx_reg;
  reg busy_reg;
  reg paramFull_reg;
  reg rxEnable_reg;
  reg rxSelective_reg;
  reg [7:0] match1_reg;
  reg [7:0] match2_reg;
  reg [15:0] txLenCmd_reg;
  reg [7:0] txAddrCmd_reg;
  reg [7:0] txCtrlCmd_reg;
  reg txTranspCmd_reg;
  reg txStartPulse_reg;
  reg txAbortPulse_reg;
  reg [2:0] need;
  wire [7:0] mask = paramMem_reg[0];
  wire cmdWrite = hostWr && hostAddr == `HDLC_A_CMD_STAT;
  wire parmWrite = hostWr && hostAddr == `HDLC_A_PARM_RES;
  wire execNow = busy_reg && paramIdx_reg == need;
  wire takeParam = busy_reg && paramFull_reg && paramIdx_reg < need;

  always @*
  begin
    case (cmd_reg)
      `HDLC_C_DLY_SET, `HDLC_C_DLY_RST, `HDLC_C_XFR_SET, `HDLC_C_XFR_RST,
      `HDLC_C_OPM_SET, `HDLC_C_OPM_RST, `HDLC_C_SER_SET, `HDLC_C_SER_RST,
      `HDLC_C_PB_SET, `HDLC_C_PB_RST: need = 3'h1;
      `HDLC_C_RX_GEN, `HDLC_C_TX_TRN: need = 3'h2;
      `HDLC_C_RX_SEL, `HDLC_C_TX_FRM: need = 3'h4;
      default: need = 3'h0;
    endcase
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      opMode_reg <= `HDLC_MODE_RESET;
      serMode_reg <= `HDLC_MODE_RESET;
      xfrMode_reg <= `HDLC_MODE_RESET;
      dlyMode_reg <= `HDLC_MODE_RESET;
      cmd_reg <= 8'h00;
      param_reg <= 8'h00;
      paramIdx_reg <= 3'h0;
      busy_reg <= 1'b0;
      paramFull_reg <= 1'b0;
      rxEnable_reg <= 1'b0;
      rxSelective_reg <= 1'b0;
      match1_reg <= 8'h00;
      match2_reg <= 8'h00;
      txLenCmd_reg <= 16'h0000;
      txAddrCmd_reg <= 8'h00;
      txCtrlCmd_reg <= 8'h00;
      txTranspCmd_reg <= 1'b0;
      txStartPulse_reg <= 1'b0;
      txAbortPulse_reg <= 1'b0;
    end
    else
    begin
      txStartPulse_reg <= 1'b0;
      txAbortPulse_reg <= 1'b0;
      if (takeParam)
      begin
        paramMem_reg[paramIdx_reg[1:0]] <= param_reg;
        paramIdx_reg <= paramIdx_reg + 3'h1;
        paramFull_reg <= 1'b0;
      end
      if (parmWrite)
      begin
        param_reg <= hostWrData;
        paramFull_reg <= 1'b1;
      end
      if (execNow)
      begin
        busy_reg <= 1'b0;
        case (cmd_reg)
          `HDLC_C_DLY_SET: dlyMode_reg <= dlyMode_reg | mask;
          `HDLC_C_DLY_RST: dlyMode_reg <= dlyMode_reg & mask;
          `HDLC_C_XFR_SET: xfrMode_reg <= xfrMode_reg | mask;
          `HDLC_C_XFR_RST: xfrMode_reg <= xfrMode_reg & mask;
          `HDLC_C_OPM_SET: opMode_reg <= opMode_reg | mask;
          `HDLC_C_OPM_RST: opMode_reg <= opMode_reg & mask;
          `HDLC_C_SER_SET: serMode_reg <= serMode_reg | mask;
          `HDLC_C_SER_RST: serMode_reg <= serMode_reg & mask;
          `HDLC_C_RX_GEN, `HDLC_C_RX_SEL:
          begin
            rxEnable_reg <= 1'b1;
            rxSelective_reg <= cmd_reg == `HDLC_C_RX_SEL;
            match1_reg <= paramMem_reg[2];
            match2_reg <= paramMem_reg[3];
          end
          `HDLC_C_RX_DIS: rxEnable_reg <= 1'b0;
          `HDLC_C_TX_FRM, `HDLC_C_TX_TRN:
          begin
            txLenCmd_reg <= {paramMem_reg[1], paramMem_reg[0]};
            txAddrCmd_reg <= paramMem_reg[2];
            txCtrlCmd_reg <= paramMem_reg[3];
            txTranspCmd_reg <= cmd_reg == `HDLC_C_TX_TRN;
            txStartPulse_reg <= 1'b1;
          end
          `HDLC_C_AB_FRM, `HDLC_C_AB_TRN: txAbortPulse_reg <= 1'b1;
          default: txAbortPulse_reg <= 1'b0;
        endcase
      end
      // A command written while busy restarts the phase
      if (cmdWrite)
      begin
        cmd_reg <= hostWrData;
        busy_reg <= 1'b1;
        paramIdx_reg <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  localparam TX_IDLE = 3'h0;
  localparam TX_PRE = 3'h1;
  localparam TX_OPEN = 3'h2;
  localparam TX_ADDR = 3'h3;
  localparam TX_CTRL = 3'h4;
  localparam TX_DATA = 3'h5;
  localparam TX_CLOSE = 3'h6;
  reg [2:0] txState_reg;
  reg [7:0] txShift_reg;
  reg [2:0] txBitCnt_reg;
  reg [2:0] txOnes_reg;
  reg txNoStuff_reg;
  reg txLine_reg;
  reg txReq_reg;
  reg txPre_reg;
  reg txEarly_reg;
  reg [15:0] txLenLeft_reg;
  reg [7:0] txHold_reg;
  reg txHoldValid_reg;
  reg [7:0] txRes_reg;
  reg txResPend_reg;
  wire nrzi = serMode_reg[`HDLC_SER_NRZI];
  wire txStuff = !txNoStuff_reg && txOnes_reg == `HDLC_ONES_STUFF;
  wire txOut = txStuff ? 1'b0 : txShift_reg[0];
  wire txLoad = txFall && !txStuff && txBitCnt_reg == 3'h7;
  wire txBody = txState_reg == TX_OPEN ||
                (txState_reg == TX_CLOSE && txReq_reg);
  assign txByteReady = !txHoldValid_reg && txLenLeft_reg != 16'h0000;
  wire txResRead = hostRd && hostAddr == `HDLC_A_TX_RES;

  task txPost;
    input [7:0] code;
    begin
      txRes_reg <= code;
      txResPend_reg <= 1'b1;
    end
  endtask

  // Next information byte, or the closing flag once the count runs out
  task txNextData;
    begin
      txNoStuff_reg <= 1'b0;
      if (txLenLeft_reg == 16'h0000)
      begin
        txShift_reg <= `HDLC_FLAG;
        txNoStuff_reg <= 1'b1;
        txState_reg <= TX_CLOSE;
      end
      else if (txHoldValid_reg)
      begin
        txShift_reg <= txHold_reg;
        txHoldValid_reg <= 1'b0;
        txLenLeft_reg <= txLenLeft_reg - 16'h0001;
        txState_reg <= TX_DATA;
        if (txLenLeft_reg == 16'h0001 && opMode_reg[`HDLC_OP_EARLY])
        begin
          txPost(`HDLC_R_TX_EARLY);
          txEarly_reg <= 1'b1;
        end
      end
      else
      begin
        // Memory fell behind: end the frame with ones
        txPost(`HDLC_R_TX_UNDER);
        txShift_reg <= `HDLC_IDLE;
        txNoStuff_reg <= 1'b1;
        txLenLeft_reg <= 16'h0000;
        txState_reg <= TX_IDLE;
      end
    end
  endtask

  always @(posedge mclk)
  begin
    if (rst)
    begin
      txState_reg <= TX_IDLE;
      txShift_reg <= `HDLC_IDLE;
      txBitCnt_reg <= 3'h0;
      txOnes_reg <= 3'h0;
      txNoStuff_reg <= 1'b1;
      txLine_reg <= 1'b1;
      txReq_reg <= 1'b0;
      txPre_reg <= 1'b0;
      txEarly_reg <= 1'b0;
      txLenLeft_reg <= 16'h0000;
      txHold_reg <= 8'h00;
      txHoldValid_reg <= 1'b0;
      txRes_reg <= 8'h00;
      txResPend_reg <= 1'b0;
    end
    else
    begin
      if (txResRead)
        txResPend_reg <= 1'b0;
      if (txByteValid && txByteReady)
      begin
        txHold_reg <= txByte;
        txHoldValid_reg <= 1'b1;
      end
      if (txStartPulse_reg)
        txReq_reg <= 1'b1;
      if (txFall)
      begin
        txLine_reg <= nrzi ? (txOut ? txLine_reg : ~txLine_reg) : txOut;
        txOnes_reg <= txOut ? txOnes_reg + 3'h1 : 3'h0;
        if (!txStuff)
        begin
          txShift_reg <= {1'b1, txShift_reg[7:1]};
          txBitCnt_reg <= txBitCnt_reg + 3'h1;
        end
      end
      if (txAbortPulse_reg)
      begin
        // Idle ones after a partial frame form the abort sequence
        txState_reg <= TX_IDLE;
        txReq_reg <= 1'b0;
        txLenLeft_reg <= 16'h0000;
        txHoldValid_reg <= 1'b0;
        txPost(`HDLC_R_TX_ABORT);
      end
      else if (txLoad && txBody)
      begin
        if (txState_reg == TX_CLOSE && !txEarly_reg)
          txPost(`HDLC_R_TX_DONE);
        // The closing flag doubles as the next opening flag
        txReq_reg <= 1'b0;
        txEarly_reg <= 1'b0;
        txLenLeft_reg <= txLenCmd_reg;
        if (txTranspCmd_reg)
        begin
          txShift_reg <= `HDLC_FLAG;
          txNoStuff_reg <= 1'b1;
          txState_reg <= TX_CTRL;
        end
        else
        begin
          txShift_reg <= txAddrCmd_reg;
          txNoStuff_reg <= 1'b0;
          txState_reg <= TX_ADDR;
        end
      end
      else if (txLoad)
      begin
        case (txState_reg)
          TX_IDLE:
          begin
            txShift_reg <= `HDLC_IDLE;
            txNoStuff_reg <= 1'b1;
            if (txReq_reg && opMode_reg[`HDLC_OP_PREFRAME])
            begin
              txShift_reg <= nrzi ? `HDLC_SYNC_NRZI : `HDLC_SYNC_PLAIN;
              txPre_reg <= 1'b0;
              txState_reg <= TX_PRE;
            end
            else if (txReq_reg)
            begin
              txShift_reg <= `HDLC_FLAG;
              txState_reg <= TX_OPEN;
            end
          end
          TX_PRE:
          begin
            txNoStuff_reg <= 1'b1;
            txPre_reg <= 1'b1;
            if (txPre_reg)
            begin
              txShift_reg <= `HDLC_FLAG;
              txState_reg <= TX_OPEN;
            end
            else
              txShift_reg <= nrzi ? `HDLC_SYNC_NRZI : `HDLC_SYNC_PLAIN;
          end
          TX_ADDR:
          begin
            txShift_reg <= txCtrlCmd_reg;
            txState_reg <= TX_CTRL;
          end
          TX_CTRL, TX_DATA: txNextData;
          TX_CLOSE:
          begin
            if (!txEarly_reg || opMode_reg[`HDLC_OP_EARLY])
              txPost(`HDLC_R_TX_DONE);
            txEarly_reg <= 1'b0;
            txShift_reg <= `HDLC_IDLE;
            txNoStuff_reg <= 1'b1;
            txState_reg <= TX_IDLE;
          end
          default: txState_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  reg rxPrevLine_reg;
  reg rxDelay_reg;
  reg [3:0] rxOnes_reg;
  reg [7:0] rxShift_reg;
  reg [2:0] rxBitCnt_reg;
  reg rxInFrame_reg;
  reg rxMatch2_reg;
  reg [15:0] rxLen_reg;
  reg [7:0] rxAddr_reg;
  reg [7:0] rxCtrl_reg;
  reg [7:0] rxRes_reg [0:4];
  reg [2:0] rxResCnt_reg;
  reg [2:0] rxResIdx_reg;
  reg rxResPend_reg;
  reg rxPush_reg;
  reg [7:0] rxPushData_reg;
  reg [1:0] rxCount_reg;
  wire buffered = opMode_reg[`HDLC_OP_BUFFERED];
  wire rxLine = serMode_reg[`HDLC_SER_DATLOOP] ? txLine_reg : pinS2_reg[2];
  wire rxBit = nrzi ? rxLine == rxPrevLine_reg : rxLine;
  wire [7:0] rxByteNow = {rxBit, rxShift_reg[7:1]};
  wire [3:0] abortLen = opMode_reg[`HDLC_OP_ABORTSEL] ?
                        `HDLC_ABORT_HDLC : `HDLC_ABORT_LINK;
  wire rxResRead = hostRd && hostAddr == `HDLC_A_RX_RES;
  wire rxFull = rxCount_reg == 2'h2;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      rxPrevLine_reg <= 1'b1;
      rxDelay_reg <= 1'b1;
      rxOnes_reg <= 4'h0;
      rxShift_reg <= 8'h00;
      rxBitCnt_reg <= 3'h0;
      rxInFrame_reg <= 1'b0;
      rxMatch2_reg <= 1'b0;
      rxLen_reg <= 16'h0000;
      rxAddr_reg <= 8'h00;
      rxCtrl_reg <= 8'h00;
      rxResCnt_reg <= 3'h0;
      rxResIdx_reg <= 3'h0;
      rxResPend_reg <= 1'b0;
      rxPush_reg <= 1'b0;
      rxPushData_reg <= 8'h00;
    end
    else
    begin
      rxPush_reg <= 1'b0;
      if (rxResRead && rxResPend_reg)
      begin
        rxResIdx_reg <= rxResIdx_reg + 3'h1;
        if (rxResIdx_reg + 3'h1 == rxResCnt_reg)
          rxResPend_reg <= 1'b0;
      end
      if (rxTick)
      begin
        rxPrevLine_reg <= rxLine;
        rxDelay_reg <= rxLine;
        if (rxBit && rxOnes_reg + 4'h1 >= abortLen)
        begin
          rxOnes_reg <= abortLen;
          // Ones straight after a closing flag are idle, not an abort
          if (rxInFrame_reg && rxLen_reg != 16'h0000)
          begin
            rxRes_reg[0] <= `HDLC_R_RX_ABORT;
            rxResCnt_reg <= 3'h1;
            rxResIdx_reg <= 3'h0;
            rxResPend_reg <= 1'b1;
          end
          rxInFrame_reg <= 1'b0;
        end
        else if (!rxBit && rxOnes_reg == `HDLC_ONES_FLAG)
        begin
          rxOnes_reg <= 4'h0;
          rxBitCnt_reg <= 3'h0;
          rxLen_reg <= 16'h0000;
          rxInFrame_reg <= rxEnable_reg;
          if (rxInFrame_reg && rxLen_reg != 16'h0000)
          begin
            rxRes_reg[0] <= rxMatch2_reg ? `HDLC_R_RX_MATCH2 :
                                           `HDLC_R_RX_MATCH1;
            rxRes_reg[1] <= rxLen_reg[7:0];
            rxRes_reg[2] <= rxLen_reg[15:8];
            rxRes_reg[3] <= rxAddr_reg;
            rxRes_reg[4] <= rxCtrl_reg;
            rxResCnt_reg <= buffered ? 3'h5 : 3'h3;
            rxResIdx_reg <= 3'h0;
            rxResPend_reg <= 1'b1;
          end
        end
        else if (!rxBit && rxOnes_reg == {1'b0, `HDLC_ONES_STUFF})
          rxOnes_reg <= 4'h0;
        else if (!rxBit || rxOnes_reg < {1'b0, `HDLC_ONES_STUFF})
        begin
          rxOnes_reg <= rxBit ? rxOnes_reg + 4'h1 : 4'h0;
          rxShift_reg <= rxByteNow;
          rxBitCnt_reg <= rxBitCnt_reg + 3'h1;
          if (rxBitCnt_reg == 3'h7 && rxInFrame_reg)
          begin
            rxLen_reg <= rxLen_reg + 16'h0001;
            if (rxLen_reg == 16'h0000)
            begin
              rxAddr_reg <= rxByteNow;
              // General receive always reports a first-address match
              rxMatch2_reg <= rxSelective_reg && rxByteNow == match2_reg &&
                              rxByteNow != match1_reg;
              if (rxSelective_reg && rxByteNow != match1_reg &&
                  rxByteNow != match2_reg)
                rxInFrame_reg <= 1'b0;
            end
            if (rxLen_reg == 16'h0001)
              rxCtrl_reg <= rxByteNow;
            rxPush_reg <= !(buffered && rxLen_reg < 16'h0002);
            rxPushData_reg <= rxByteNow;
          end
        end
        else
          rxOnes_reg <= rxOnes_reg + 4'h1;
      end
      // A full buffer ends reception with an overrun result
      if (rxPush_reg && rxFull)
      begin
        rxRes_reg[0] <= `HDLC_R_RX_OVERRUN;
        rxResCnt_reg <= 3'h1;
        rxResIdx_reg <= 3'h0;
        rxResPend_reg <= 1'b1;
        rxInFrame_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry receive buffer
  // ----------------------------------------------------------------
  reg [7:0] rxBuf_reg [0:1];
  reg rxWrPtr_reg;
  reg rxRdPtr_reg;
  wire rxIn = rxPush_reg && !rxFull;
  wire rxOut = rxByteValid && rxByteReady;
  assign rxByteValid = rxCount_reg != 2'h0;
  assign rxByteData = rxBuf_reg[rxRdPtr_reg];
  genvar e;
  generate
    for (e = 0; e < 2; e = e + 1)
    begin : gEntry
      always @(posedge mclk)
      begin
        if (rst)
          rxBuf_reg[e] <= 8'h00;
        else if (rxIn && rxWrPtr_reg == e)
          rxBuf_reg[e] <= rxPushData_reg;
      end
    end
  endgenerate
  always @(posedge mclk)
  begin
    if (rst)
    begin
      rxWrPtr_reg <= 1'b0;
      rxRdPtr_reg <= 1'b0;
      rxCount_reg <= 2'h0;
    end
    else
    begin
      if (rxIn)
        rxWrPtr_reg <= ~rxWrPtr_reg;
      if (rxOut)
        rxRdPtr_reg <= ~rxRdPtr_reg;
      rxCount_reg <= rxCount_reg + {1'b0, rxIn} - {1'b0, rxOut};
    end
  end

  // ----------------------------------------------------------------
  // Requests, status and read port
  // ----------------------------------------------------------------
  wire intMode = xfrMode_reg[`HDLC_XFR_INT];
  assign txDmaReq = !intMode && txByteReady;
  assign rxDmaReq = !intMode && rxByteValid;
  assign txIrq = txResPend_reg || (intMode && txByteReady);
  assign rxIrq = rxResPend_reg || (intMode && rxByteValid);
  wire [7:0] status = {busy_reg, busy_reg, paramFull_reg, 1'b0,
                       rxIrq, txIrq, rxResPend_reg, txResPend_reg};
  always @(posedge mclk)
  begin
    if (rst)
    begin
      hostRdData <= 8'h00;
      txDataPin <= 1'b1;
    end
    else
    begin
      txDataPin <= dlyMode_reg[`HDLC_DLY_ON] ? rxDelay_reg : txLine_reg;
      if (hostRd)
      begin
        case (hostAddr)
          `HDLC_A_CMD_STAT: hostRdData <= status;
          `HDLC_A_TX_RES: hostRdData <= txRes_reg;
          `HDLC_A_RX_RES: hostRdData <= rxRes_reg[rxResIdx_reg];
          default: hostRdData <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* File: rtl/hdlc_consts.vh */
// Constants of the frame controller command and mode block
`ifndef HDLC_CONSTS_VH
`define HDLC_CONSTS_VH
// Host port addresses (write side / read side)
`define HDLC_A_CMD_STAT 2'h0
`define HDLC_A_PARM_RES 2'h1
`define HDLC_A_TX_RES 2'h2
`define HDLC_A_RX_RES 2'h3
// Mode register set/reset commands
`define HDLC_C_DLY_SET 8'ha4
`define HDLC_C_DLY_RST 8'h64
`define HDLC_C_XFR_SET 8'h97
`define HDLC_C_XFR_RST 8'h57
`define HDLC_C_OPM_SET 8'h91
`define HDLC_C_OPM_RST 8'h51
`define HDLC_C_SER_SET 8'ha0
`define HDLC_C_SER_RST 8'h60
// Receive, transmit and port commands
`define HDLC_C_RX_GEN 8'hc0
`define HDLC_C_RX_SEL 8'hc1
`define HDLC_C_RX_DIS 8'hc5
`define HDLC_C_TX_FRM 8'hc8
`define HDLC_C_TX_TRN 8'hc9
`define HDLC_C_AB_FRM 8'hcc
`define HDLC_C_AB_TRN 8'hcd
`define HDLC_C_PB_SET 8'ha3
`define HDLC_C_PB_RST 8'h63
// Mode register reset value and field positions
`define HDLC_MODE_RESET 8'hff
`define HDLC_OP_PREFRAME 1
`define HDLC_OP_BUFFERED 2
`define HDLC_OP_EARLY 3
`define HDLC_OP_ABORTSEL 5
`define HDLC_SER_NRZI 0
`define HDLC_SER_CLKLOOP 1
`define HDLC_SER_DATLOOP 2
`define HDLC_XFR_INT 0
`define HDLC_DLY_ON 0
// Status register bits
`define HDLC_ST_TXRES 0
`define HDLC_ST_RXRES 1
`define HDLC_ST_TXINT 2
`define HDLC_ST_RXINT 3
`define HDLC_ST_PFULL 5
`define HDLC_ST_CFULL 6
`define HDLC_ST_BUSY 7
// Line characters
`define HDLC_FLAG 8'h7e
`define HDLC_IDLE 8'hff
`define HDLC_SYNC_NRZI 8'h00
`define HDLC_SYNC_PLAIN 8'h55
// Result codes
`define HDLC_R_TX_EARLY 8'h0c
`define HDLC_R_TX_DONE 8'h0d
`define HDLC_R_TX_UNDER 8'h0e
`define HDLC_R_TX_ABORT 8'h10
`define HDLC_R_RX_MATCH1 8'h00
`define HDLC_R_RX_MATCH2 8'h01
`define HDLC_R_RX_ABORT 8'h04
`define HDLC_R_RX_OVERRUN 8'h08
// Run lengths of ones on the line
`define HDLC_ONES_STUFF 3'h5
`define HDLC_ONES_FLAG 4'h6
`define HDLC_ABORT_HDLC 4'h7
`define HDLC_ABORT_LINK 4'h8
`endif

/* File: verification/hdlc_cmd_mode_monitor.sv */
// Port checker for the command and mode block
`timescale 1ns/10ps
module hdlc_cmd_mode_monitor
(
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Host port
  input wire [1:0] hostAddr,
  input wire hostWr,
  input wire hostRd,
  input wire [7:0] hostWrData,
  input wire [7:0] hostRdData,
  // Streams and requests
  input wire txByteValid,
  input wire txByteReady,
  input wire rxByteValid,
  input wire txDmaReq,
  input wire rxDmaReq,
  input wire txIrq,
  input wire rxIrq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire statRd = hostRd && hostAddr == 2'h0;
  wire modeWr = hostWr && hostAddr == 2'h0 &&
    (hostWrData inside {8'ha4, 8'h64, 8'h97, 8'h57,
    8'h91, 8'h51, 8'ha0, 8'h60});
  tx_dma_a: assert property (txDmaReq |-> txByteReady)
    else $error("tx dma");
  rx_dma_a: assert property (rxDmaReq |-> rxByteValid)
    else $error("rx dma");
  hold_drop_a: assert property (txByteValid && txByteReady |=>
    !txByteReady) else $error("tx ready");
  rd_hold_a: assert property (!hostRd |=> $stable(hostRdData))
    else $error("read hold");
  stat_bits_a: assert property (statRd |=> !hostRdData[4] &&
    hostRdData[6] == hostRdData[7]) else $error("status bits");
  stat_irq_a: assert property (statRd |=>
    hostRdData[3:2] == $past({rxIrq, txIrq})) else $error("status irq");
  imm_zero_a: assert property (hostRd && hostAddr == 2'h1 |=>
    hostRdData == 8'h00) else $error("immediate");
  mode_quiet_a: assert property (modeWr |=>
    (!$rose(txIrq) && !$rose(rxIrq)) [*8]) else $error("mode irq");
  cover property (txByteValid && txByteReady);
  cover property (modeWr);
  cover property (hostRd && hostAddr == 2'h3);
endmodule
bind hdlc_cmd_mode hdlc_cmd_mode_monitor mon (.*);

/* File: verification/hdlc_dma_peer.sv */
// Memory-side stream model standing in for the DMA controller
`timescale 1ns/10ps
module hdlc_dma_peer
(
  // Clock
  input wire mclk,
  // Transmit stream
  input wire txDmaReq,
  input wire txByteReady,
  output wire [7:0] txByte,
  output reg txByteValid = 1'b0,
  // Receive stream
  input wire [7:0] rxByteData,
  input wire rxByteValid,
  output reg rxByteReady = 1'b0,
  output reg [7:0] rxCount = 8'h00
);
  // Idle pattern differs from the real byte so a stale sample shows
  assign txByte = txByteValid ? 8'h5a : 8'ha5;
  always @(posedge mclk)
  begin
    // Answer a cycle late, hold until taken
    txByteValid <= txDmaReq && !(txByteValid && txByteReady);
    // Drain every other cycle to stall the receive buffer
    rxByteReady <= ~rxByteReady;
    if (rxByteValid && rxByteReady)
      rxCount <= rxCount + 8'h01;
  end
endmodule

/* File: verification/hdlc_cmd_mode_bench.sv */
// Self-checking bench for the command and mode block
`timescale 1ns/10ps
module hdlc_cmd_mode_bench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg txClkPin = 1'b0;
  reg rxClkPin = 1'b0;
  reg rxDataPin = 1'b1;
  reg [1:0] hostAddr = 2'h0;
  reg hostWr = 1'b0;
  reg hostRd = 1'b0;
  reg [7:0] hostWrData = 8'h00;
  wire [7:0] hostRdData, txByte, rxByteData, rxCount;
  wire txByteValid, txByteReady, rxByteValid, rxByteReady;
  wire txDmaReq, rxDmaReq, txIrq, rxIrq, txDataPin;
  integer errors = 0;
  integer checkCount = 0;
  integer cyc = 0;
  integer i;
  hdlc_cmd_mode dut (.*);
  hdlc_dma_peer peer (.*);
  initial forever #2.5 mclk = ~mclk;
  // Offset keeps link clock edges off the system clock edges
  initial
  begin
    #1.3;
    forever #62.5 txClkPin = ~txClkPin;
  end
  task end_sim;
  begin
    $display("errors %0d checks %0d", errors, checkCount);
    if (errors == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [39:0] n, input [7:0] e, input [7:0] g);
  begin
    checkCount = checkCount + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("MISMATCH %0s exp %h got %h", n, e, g);
    end
  end
  endtask
  task wr(input [1:0] a, input [7:0] d);
  begin
    @(negedge mclk);
    hostAddr = a;
    hostWrData = d;
    hostWr = 1'b1;
    @(negedge mclk);
    hostWr = 1'b0;
    repeat (2) @(negedge mclk);
  end
  endtask
  task rd(input [1:0] a, input [7:0] e);
  begin
    @(negedge mclk);
    hostAddr = a;
    hostRd = 1'b1;
    @(negedge mclk);
    hostRd = 1'b0;
    chk("read", e, hostRdData);
  end
  endtask
  task mode(input [7:0] c, input [7:0] m);
  begin
    wr(2'h0, c);
    rd(2'h0, 8'hc0);
    wr(2'h1, m);
    rd(2'h0, 8'h00);
  end
  endtask
  task waitIrq(input tx);
  begin
    i = 0;
    while ((tx ? txIrq : rxIrq) !== 1'b1 && i < 9000)
    begin
      @(negedge mclk);
      i = i + 1;
    end
  end
  endtask
  task t_modes;
  begin
    mode(8'h64, 8'h00);
    mode(8'h57, 8'h00);
    mode(8'h60, 8'h07);
    mode(8'h51, 8'h00);
    mode(8'h91, 8'h06);
    mode(8'ha4, 8'h00);
    mode(8'h97, 8'h00);
    mode(8'ha0, 8'h00);
  end
  endtask
  // Loopback frame: receiver armed first, then one data byte sent
  task t_frame;
  begin
    wr(2'h0, 8'hc0);
    wr(2'h1, 8'h10);
    wr(2'h1, 8'h00);
    wr(2'h0, 8'hc8);
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h00);
    wr(2'h1, 8'hc3);
    wr(2'h1, 8'h11);
    waitIrq(1'b1);
    rd(2'h2, 8'h0d);
    waitIrq(1'b0);
    rd(2'h3, 8'h00);
    rd(2'h3, 8'h03);
    rd(2'h3, 8'h00);
    rd(2'h3, 8'hc3);
    rd(2'h3, 8'h11);
    chk("rxcnt", 8'h01, rxCount);
  end
  endtask
  task t_early;
  begin
    wr(2'h0, 8'hc5);
    mode(8'h91, 8'h08);
    wr(2'h0, 8'hc9);
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h00);
    waitIrq(1'b1);
    rd(2'h2, 8'h0c);
    // Second frame queued before the closing flag: no 0d in between
    wr(2'h0, 8'hc9);
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h00);
    waitIrq(1'b1);
    rd(2'h2, 8'h0c);
    waitIrq(1'b1);
    rd(2'h2, 8'h0d);
  end
  endtask
  task t_refuse;
  begin
    mode(8'h60, 8'h06);
    repeat (60) @(negedge mclk);
    chk("line", 8'h01, {7'h00, txDataPin});
    wr(2'h1, 8'h33);
    rd(2'h0, 8'h20);
    rd(2'h1, 8'h00);
  end
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    rd(2'h0, 8'h00);
    t_modes;
    t_frame;
    t_early;
    t_refuse;
    end_sim;
  end
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      errors = errors + 1;
      end_sim;
    end
  end
endmodule
